// ---- limit_bank_pkg.sv ----
// Register map, reset values and field layout of the limit threshold bank
`default_nettype none
package limit_bank_pkg;
  // Register offsets on the register port
  localparam logic [7:0] OFS_DIAG = 8'h0B;
  localparam logic [7:0] OFS_SHUNT_HI = 8'h0C;
  localparam logic [7:0] OFS_SHUNT_LO = 8'h0D;
  localparam logic [7:0] OFS_RAIL_HI = 8'h0E;
  localparam logic [7:0] OFS_RAIL_LO = 8'h0F;
  localparam logic [7:0] OFS_HEAT = 8'h10;
  localparam logic [7:0] OFS_WATT = 8'h11;
  localparam logic [7:0] OFS_MAKER = 8'h3E;

  // Reset values
  localparam logic [15:0] RST_SHUNT_HI = 16'h7FFF;
  localparam logic [15:0] RST_SHUNT_LO = 16'h8000;
  localparam logic [15:0] RST_RAIL_HI = 16'h7FFF;
  localparam logic [15:0] RST_RAIL_LO = 16'h0000;
  localparam logic [15:0] RST_HEAT = 16'h7FFF;
  localparam logic [15:0] RST_WATT = 16'h0FFF;

  // Writable bit masks; reserved bits are held at zero
  localparam logic [15:0] RAIL_MASK = 16'h7FFF;
  localparam logic [15:0] HEAT_MASK = 16'hFFF0;

  // Field positions
  localparam int HEAT_LSB = 4;
  localparam int HEAT_W = 12;
  localparam int LATCH_BIT = 15;
  localparam int FLAG_LSB = 2;
  localparam int FLAG_W = 6;
  localparam int WATT_SHIFT = 8;
  localparam int POWER_W = 24;

  // Index of each condition within the flag vector (bit FLAG_LSB + index)
  localparam int FL_POWER_OVER = 0;
  localparam int FL_RAIL_UNDER = 1;
  localparam int FL_RAIL_OVER = 2;
  localparam int FL_SHUNT_UNDER = 3;
  localparam int FL_SHUNT_OVER = 4;
  localparam int FL_HEAT_OVER = 5;

  // Shunt threshold step in units of 10 nV for the two input ranges
  localparam logic [15:0] STEP_WIDE_10NV = 16'h01F4;
  localparam logic [15:0] STEP_NARROW_10NV = 16'h007D;

  // Maker code: arbitrary neutral value, two ASCII characters
  localparam logic [15:0] MAKER_CODE_DEFAULT = 16'h4142;
endpackage : limit_bank_pkg
`default_nettype wire

// ---- limit_compare.sv ----
// Over and under comparison of one measurement against its limits
`default_nettype none
module limit_compare #(
  parameter int W = 16,
  parameter bit SGN = 1'b1
) (
  input wire logic [W-1:0] value_in,  // Measurement result
  input wire logic [W-1:0] high_in,   // Upper limit
  input wire logic [W-1:0] low_in,    // Lower limit
  output logic above_out,             // Value exceeds upper limit
  output logic below_out              // Value falls below lower limit
);
  generate
    if (SGN) begin : g_signed
      assign above_out = $signed(value_in) > $signed(high_in);
      assign below_out = $signed(value_in) < $signed(low_in);
    end else begin : g_unsigned
      assign above_out = value_in > high_in;
      assign below_out = value_in < low_in;
    end
  endgenerate
endmodule : limit_compare
`default_nettype wire

// ---- limit_threshold_compare_bank.sv ----
// Limit threshold registers and the diagnostic flags they drive
// Functional notes
// - Negative shunt high limit trips at zero
// - Shunt high limit, signed 16 bits
// - Shunt low limit, signed, flags undercurrent
// - Rail high limit, unsigned 15 bits
// - Rail low limit, unsigned 15 bits
// - Rail limit bit 15 reads zero
// - Heat ceiling bits 15-4, signed compare
// - Heat ceiling bits 3-0 read zero
// - Wattage ceiling weighs 256 power steps
// - Maker identity reads fixed code
// - Six flags in diagnostic bits 7-2
// - Latched flags clear on diagnostic read
// - Range select sets shunt step size
`default_nettype none
module limit_threshold_compare_bank
  import limit_bank_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = MAKER_CODE_DEFAULT
) (
  input wire logic clk_in,                    // Device clock, 100 MHz
  input wire logic rst_n_in,                  // Asynchronous reset, active low
  input wire logic [7:0] reg_addr_in,         // Register address
  input wire logic reg_wr_in,                 // Write strobe
  input wire logic reg_rd_in,                 // Read strobe
  input wire logic [15:0] reg_wdata_in,       // Write data
  output logic [15:0] reg_rdata_out,          // Read data, one cycle after strobe
  input wire logic shunt_range_select_in,     // 0 wide range, 1 narrow range
  input wire logic [15:0] shunt_result_in,    // Shunt result, signed
  input wire logic shunt_valid_in,            // New shunt result
  input wire logic [15:0] rail_result_in,     // Bus voltage result, unsigned
  input wire logic rail_valid_in,             // New bus voltage result
  input wire logic [11:0] die_heat_result_in, // Die temperature, signed
  input wire logic die_heat_valid_in,         // New temperature result
  input wire logic [23:0] power_result_in,    // Power result, unsigned
  input wire logic power_valid_in,            // New power result
  output logic [5:0] diagnostic_flags_out,    // Flags, index 0 is bit 2
  output logic flag_latch_select_out,         // Latch mode in force
  output logic [15:0] shunt_step_out          // Shunt step in 10 nV units
);
  typedef struct packed {
    logic [15:0] shunt_hi;
    logic [15:0] shunt_lo;
    logic [15:0] rail_hi;
    logic [15:0] rail_lo;
    logic [15:0] heat;
    logic [15:0] watt;
    logic latch;
    logic [FLAG_W-1:0] flags;
    logic [15:0] rdata;
    logic [15:0] step;
  } bank_state_t;

  localparam bank_state_t BANK_RESET = '{
    shunt_hi: RST_SHUNT_HI,
    shunt_lo: RST_SHUNT_LO,
    rail_hi: RST_RAIL_HI & RAIL_MASK,
    rail_lo: RST_RAIL_LO & RAIL_MASK,
    heat: RST_HEAT & HEAT_MASK,
    watt: RST_WATT,
    latch: 1'b0,
    flags: '0,
    rdata: '0,
    step: STEP_WIDE_10NV
  };

  bank_state_t state_r;
  bank_state_t state_nxt;

  logic shunt_above;
  logic shunt_below;
  logic rail_above;
  logic rail_below;
  logic heat_above;
  logic power_above;
  logic diag_rd;
  logic [FLAG_W-1:0] new_result;
  logic [FLAG_W-1:0] cond;
  logic [POWER_W-1:0] watt_scaled;

  // Signed shunt compare; a negative high limit lies below zero
  limit_compare #(.W(16), .SGN(1'b1)) u_shunt_cmp (
    .value_in(shunt_result_in),
    .high_in(state_r.shunt_hi),
    .low_in(state_r.shunt_lo),
    .above_out(shunt_above),
    .below_out(shunt_below)
  );

  // Unsigned rail compare on the 15-bit limit fields
  limit_compare #(.W(16), .SGN(1'b0)) u_rail_cmp (
    .value_in(rail_result_in),
    .high_in(state_r.rail_hi),
    .low_in(state_r.rail_lo),
    .above_out(rail_above),
    .below_out(rail_below)
  );

  // Heat ceiling field compared directly with the die result
  limit_compare #(.W(HEAT_W), .SGN(1'b1)) u_heat_cmp (
    .value_in(die_heat_result_in),
    .high_in(state_r.heat[HEAT_LSB +: HEAT_W]),
    .low_in(die_heat_result_in),
    .above_out(heat_above),
    .below_out()
  );

  // One ceiling step is 256 power steps
  assign watt_scaled = {state_r.watt, {WATT_SHIFT{1'b0}}};

  limit_compare #(.W(POWER_W), .SGN(1'b0)) u_power_cmp (
    .value_in(power_result_in),
    .high_in(watt_scaled),
    .low_in(power_result_in),
    .above_out(power_above),
    .below_out()
  );

  assign diag_rd = reg_rd_in && (reg_addr_in == OFS_DIAG);

  always_comb begin
    state_nxt = state_r;
    new_result = '0;
    cond = '0;
    // Each flag sits at its own diagnostic bit
    new_result[FL_POWER_OVER] = power_valid_in;
    new_result[FL_RAIL_UNDER] = rail_valid_in;
    new_result[FL_RAIL_OVER] = rail_valid_in;
    new_result[FL_SHUNT_UNDER] = shunt_valid_in;
    new_result[FL_SHUNT_OVER] = shunt_valid_in;
    new_result[FL_HEAT_OVER] = die_heat_valid_in;
    cond[FL_POWER_OVER] = power_above;
    cond[FL_RAIL_UNDER] = rail_below;
    cond[FL_RAIL_OVER] = rail_above;
    cond[FL_SHUNT_UNDER] = shunt_below;
    cond[FL_SHUNT_OVER] = shunt_above;
    cond[FL_HEAT_OVER] = heat_above;

    // Flags move on a new result, or in latch mode on a diagnostic read; compares use the limits in force now
    if (state_r.latch) begin
      // Set wins over the clearing read
      state_nxt.flags = (state_r.flags & ~({FLAG_W{diag_rd}})) | (new_result & cond);
    end else begin
      // Transparent: each flag follows its latest comparison
      state_nxt.flags = (state_r.flags & ~new_result) | (new_result & cond);
    end

    // Step size follows the range select
    state_nxt.step = shunt_range_select_in ? STEP_NARROW_10NV : STEP_WIDE_10NV;

    // Writes; reserved bits are masked off and keep reading zero
    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_DIAG: state_nxt.latch = reg_wdata_in[LATCH_BIT];
        OFS_SHUNT_HI: state_nxt.shunt_hi = reg_wdata_in;
        OFS_SHUNT_LO: state_nxt.shunt_lo = reg_wdata_in;
        OFS_RAIL_HI: state_nxt.rail_hi = reg_wdata_in & RAIL_MASK;
        OFS_RAIL_LO: state_nxt.rail_lo = reg_wdata_in & RAIL_MASK;
        OFS_HEAT: state_nxt.heat = reg_wdata_in & HEAT_MASK;
        OFS_WATT: state_nxt.watt = reg_wdata_in;
        default: state_nxt.latch = state_r.latch;
      endcase
    end

    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_DIAG: begin
          state_nxt.rdata = '0;
          state_nxt.rdata[LATCH_BIT] = state_r.latch;
          state_nxt.rdata[FLAG_LSB +: FLAG_W] = state_r.flags;
        end
        OFS_SHUNT_HI: state_nxt.rdata = state_r.shunt_hi;
        OFS_SHUNT_LO: state_nxt.rdata = state_r.shunt_lo;
        OFS_RAIL_HI: state_nxt.rdata = state_r.rail_hi;
        OFS_RAIL_LO: state_nxt.rdata = state_r.rail_lo;
        OFS_HEAT: state_nxt.rdata = state_r.heat;
        OFS_WATT: state_nxt.rdata = state_r.watt;
        OFS_MAKER: state_nxt.rdata = MAKER_CODE;
        default: state_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= BANK_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_out = state_r.rdata;
  assign diagnostic_flags_out = state_r.flags;
  assign flag_latch_select_out = state_r.latch;
  assign shunt_step_out = state_r.step;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_diag_read;
    reg_rd_in && (reg_addr_in == OFS_DIAG);
  endsequence

  sequence s_no_result;
    !shunt_valid_in && !rail_valid_in && !die_heat_valid_in && !power_valid_in;
  endsequence

  a_shunt_zero_trip: assert property (
    shunt_valid_in && (shunt_result_in == 16'h0000) && state_r.shunt_hi[15]
    |=> state_r.flags[FL_SHUNT_OVER])
    else $error("shunt high flag missed at zero");

  a_rail_top_zero: assert property (
    !state_r.rail_hi[15] && !state_r.rail_lo[15])
    else $error("rail limit top bit not zero");

  a_heat_low_zero: assert property (
    reg_rd_in && (reg_addr_in == OFS_HEAT) |=> reg_rdata_out[3:0] == 4'h0)
    else $error("heat ceiling low bits not zero");

  a_maker_read: assert property (
    reg_rd_in && (reg_addr_in == OFS_MAKER) |=> reg_rdata_out == MAKER_CODE)
    else $error("maker code wrong");

  a_latch_hold: assert property (
    state_r.latch && !reg_wr_in && !(reg_rd_in && (reg_addr_in == OFS_DIAG))
    |=> (($past(state_r.flags) & ~state_r.flags) == '0))
    else $error("latched flag fell without read");

  a_latch_clear: assert property (
    state_r.latch ##0 s_no_result ##0 s_diag_read |=> state_r.flags == '0)
    else $error("latched flags not cleared by read");

  a_rail_over_follow: assert property (
    !state_r.latch && rail_valid_in
    |=> state_r.flags[FL_RAIL_OVER] == ($past(rail_result_in) > $past(state_r.rail_hi)))
    else $error("rail high flag wrong");

  a_power_scale: assert property (
    !state_r.latch && power_valid_in
    |=> state_r.flags[FL_POWER_OVER]
        == ($past(power_result_in) > {$past(state_r.watt), 8'h00}))
    else $error("power flag wrong");

  a_range_step: assert property (
    shunt_range_select_in ##1 shunt_range_select_in |-> shunt_step_out == STEP_NARROW_10NV)
    else $error("narrow step wrong");

  a_limit_hold: assert property (
    !(reg_wr_in && (reg_addr_in == OFS_SHUNT_HI)) |=> $stable(state_r.shunt_hi))
    else $error("shunt high limit changed without write");

  a_diag_layout: assert property (
    s_diag_read |=> reg_rdata_out[FLAG_LSB +: FLAG_W] == $past(state_r.flags))
    else $error("diagnostic flag layout wrong");
endmodule : limit_threshold_compare_bank
`default_nettype wire

// ---- reg_host.sv ----
// Register host model that drives the device register port
`default_nettype none
module reg_host (
  input wire logic clk_in,            // Device clock
  input wire logic [15:0] rdata_in,   // Read data from the device
  output logic [7:0] addr_out,        // Register address
  output logic wr_out,                // Write strobe
  output logic rd_out,                // Read strobe
  output logic [15:0] wdata_out       // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end
  // One-cycle write pulse, launched and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
  endtask : wr
  // Read data is registered at the strobe edge, so it is settled here
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask : rd
endmodule : reg_host
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the limit threshold bank
`default_nettype none
module testbench
  import limit_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [15:0] r; logic [15:0] w; logic [15:0] e;} row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rng = 1'b0;
  logic [3:0] vld = 4'h0;
  logic [15:0] sh = 16'h0000;
  logic [15:0] rl = 16'h0000;
  logic [11:0] ht = 12'h000;
  logic [23:0] pw = 24'h00_0000;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [5:0] flags;
  logic latch;
  logic [15:0] step;
  logic [15:0] d;
  int fails = 0;
  int cmp_count = 0;
  row_t rows [8] = '{
    '{OFS_SHUNT_HI, 16'h7fff, 16'h1234, 16'h1234},
    '{OFS_SHUNT_LO, 16'h8000, 16'hfedc, 16'hfedc},
    '{OFS_RAIL_HI, 16'h7fff, 16'hffff, 16'h7fff},
    '{OFS_RAIL_LO, 16'h0000, 16'h8001, 16'h0001},
    '{OFS_HEAT, 16'h7ff0, 16'hffff, 16'hfff0},
    '{OFS_WATT, 16'h0fff, 16'habcd, 16'habcd},
    '{OFS_MAKER, MAKER_CODE_DEFAULT, 16'h0000, MAKER_CODE_DEFAULT},
    '{8'h20, 16'h0000, 16'hffff, 16'h0000}};

  initial begin
    forever #5 clk = ~clk;
  end

  reg_host host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata));

  limit_threshold_compare_bank DUT (.clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .shunt_range_select_in(rng), .shunt_result_in(sh), .shunt_valid_in(vld[0]),
    .rail_result_in(rl), .rail_valid_in(vld[1]), .die_heat_result_in(ht),
    .die_heat_valid_in(vld[2]), .power_result_in(pw), .power_valid_in(vld[3]),
    .diagnostic_flags_out(flags), .flag_latch_select_out(latch), .shunt_step_out(step));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Presents one result of every quantity, then checks the flags
  task automatic meas(input logic [15:0] s, input logic [15:0] r, input logic [11:0] t,
      input logic [23:0] p, input logic [5:0] e);
    @(negedge clk);
    sh = s;
    rl = r;
    ht = t;
    pw = p;
    vld = 4'hf;
    @(negedge clk);
    vld = 4'h0;
    chk("flags", {10'h000, flags}, {10'h000, e});
  endtask : meas

  task automatic print_verdict;
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("flags_rst", {10'h000, flags}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      host.rd(rows[i].a, d);
      chk("reset_value", d, rows[i].r);
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, d);
      chk("readback", d, rows[i].e);
    end
    // Both shunt limits negative, larger one in the high limit
    host.wr(OFS_SHUNT_HI, 16'hfff0);
    host.wr(OFS_SHUNT_LO, 16'hff00);
    meas(16'h0000, 16'h0000, 12'h000, 24'h00_0000, 6'b110010);
    host.wr(OFS_RAIL_HI, 16'h0100);
    host.wr(OFS_WATT, 16'h0001);
    meas(16'hfeff, 16'h0101, 12'hfff, 24'h00_0101, 6'b001101);
    meas(16'hff00, 16'h0100, 12'hfff, 24'h00_0100, 6'b000000);
    host.wr(OFS_DIAG, 16'h8000);
    chk("latch", {15'h0000, latch}, 16'h0001);
    meas(16'h0000, 16'h0001, 12'hfff, 24'h00_0000, 6'b010000);
    meas(16'hff00, 16'h0001, 12'hfff, 24'h00_0000, 6'b010000);
    host.rd(OFS_DIAG, d);
    chk("diag_read", d, 16'h8040);
    chk("flags_clr", {10'h000, flags}, 16'h0000);
    // A shunt trip in the very cycle of the clearing read must survive it
    fork
      host.rd(OFS_DIAG, d);
      begin
        @(negedge clk);
        sh = 16'h0000;
        vld = 4'h1;
        @(negedge clk);
        vld = 4'h0;
      end
    join
    chk("diag_empty", d, 16'h8000);
    chk("set_wins", {10'h000, flags}, 16'h0010);
    host.wr(OFS_DIAG, 16'h0000);
    @(negedge clk);
    rng = 1'b1;
    repeat (2) @(negedge clk);
    chk("step_narrow", step, STEP_NARROW_10NV);
    rng = 1'b0;
    repeat (2) @(negedge clk);
    chk("step_wide", step, STEP_WIDE_10NV);
    meas(16'h0000, 16'h0000, 12'h000, 24'h00_0000, 6'b110010);
    // Only the rail result is new: the other flags must keep their state
    @(negedge clk);
    sh = 16'hff80;
    rl = 16'h0200;
    ht = 12'h800;
    vld = 4'h2;
    @(negedge clk);
    vld = 4'h0;
    chk("flags_own", {10'h000, flags}, 16'h0034);
    rst_n = 1'b0;
    @(negedge clk);
    chk("flags_rst2", {10'h000, flags}, 16'h0000);
    rst_n = 1'b1;
    host.rd(OFS_RAIL_HI, d);
    chk("rail_hi_rst2", d, 16'h7fff);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
